// ==== tw_timer.sv ====
// Eight-bit timer with two compare channels, waveform outputs and event flags.
`timescale 1ns/1ps
`include "tw_consts.svh"
module tw_timer (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    output logic [7:0] REG_RDATA,
    input wire logic VEC_ACK_OVF,
    input wire logic VEC_ACK_A,
    input wire logic VEC_ACK_B,
    output logic FLAG_OVF,
    output logic FLAG_MATCH_A,
    output logic FLAG_MATCH_B,
    output logic WAVE_OUT_A,
    output logic WAVE_OUT_A_EN,
    output logic WAVE_OUT_B,
    output logic WAVE_OUT_B_EN
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] ctl_a_q;
    logic [7:0] ctl_a_d;
    logic [3:0] ctl_b_q;
    logic [3:0] ctl_b_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] oca_buf_q;
    logic [7:0] oca_buf_d;
    logic [7:0] oca_q;
    logic [7:0] oca_d;
    logic [7:0] ocb_buf_q;
    logic [7:0] ocb_buf_d;
    logic [7:0] ocb_q;
    logic [7:0] ocb_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;
    logic [2:0] flg_q;
    logic [2:0] flg_d;
    logic blk_q;
    logic blk_d;
    logic wa_q;
    logic wa_d;
    logic wb_q;
    logic wb_d;
    tw_pkg::tw_dir_e dir_q;
    tw_pkg::tw_dir_e dir_d;

    tw_pkg::tw_mode_e mode;
    tw_pkg::tw_act_e act_a;
    tw_pkg::tw_act_e act_b;
    logic wr_ctl_a;
    logic wr_ctl_b;
    logic wr_cnt;
    logic wr_oca;
    logic wr_ocb;
    logic wr_flg;
    logic is_fast;
    logic is_pc;
    logic non_pwm;
    logic top_oca;
    logic [7:0] top;
    logic tick;
    logic at_top;
    logic at_bot;
    logic hit_a;
    logic hit_b;
    logic ovf_ev;
    logic turn;
    logic upd;
    logic force_a;
    logic force_b;
    logic [2:0] flg_clr;

    tw_pscl_if pif ();

    tw_prescaler #(
        .PW(`TW_PRE_W)
    ) u_prescaler (
        .MCLK(MCLK),
        .ARST_N(ARST_N),
        .pif(pif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Channel action

    // One decoder serves both channels; only channel A may toggle in PWM modes.
    function automatic tw_pkg::tw_act_e chan_act(
        input logic [1:0] com,
        input logic hit,
        input logic ocr_top,
        input logic tog_ok,
        input logic fast,
        input logic pc,
        input logic up,
        input logic turn_now
    );
        chan_act = tw_pkg::TW_HOLD;
        if (!fast && !pc) begin
            if (hit) begin
                chan_act = tw_pkg::tw_act_e'(com);
            end
        end else if (com == 2'h1) begin
            if (hit && tog_ok) begin
                chan_act = tw_pkg::TW_TOGGLE;
            end
        end else if (com[1]) begin
            // A compare equal to TOP is ignored; the TOP or BOTTOM action alone shapes the output.
            if (hit && !ocr_top) begin
                chan_act = (com[0] ^ (pc && !up)) ? tw_pkg::TW_SET : tw_pkg::TW_CLEAR;
            end else if (turn_now && (fast || ocr_top)) begin
                chan_act = com[0] ? tw_pkg::TW_CLEAR : tw_pkg::TW_SET;
            end
        end
    endfunction : chan_act

    function automatic logic apply_act(input logic cur, input tw_pkg::tw_act_e act);
        case (act)
            tw_pkg::TW_TOGGLE: apply_act = ~cur;
            tw_pkg::TW_CLEAR: apply_act = 1'b0;
            tw_pkg::TW_SET: apply_act = 1'b1;
            default: apply_act = cur;
        endcase
    endfunction : apply_act

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    assign wr_ctl_a = REG_WE && (REG_ADDR == `TW_OFS_CTRL_A);
    assign wr_ctl_b = REG_WE && (REG_ADDR == `TW_OFS_CTRL_B);
    assign wr_cnt = REG_WE && (REG_ADDR == `TW_OFS_COUNT);
    assign wr_oca = REG_WE && (REG_ADDR == `TW_OFS_CMP_A);
    assign wr_ocb = REG_WE && (REG_ADDR == `TW_OFS_CMP_B);
    assign wr_flg = REG_WE && (REG_ADDR == `TW_OFS_FLAGS);

    assign mode = tw_pkg::tw_mode_e'({ctl_b_q[`TW_F_MODE_HI], ctl_a_q[`TW_F_MODE_LO]});
    assign is_fast = (mode == tw_pkg::TW_FAST_FF) || (mode == tw_pkg::TW_FAST_OCA);
    assign is_pc = (mode == tw_pkg::TW_PC_FF) || (mode == tw_pkg::TW_PC_OCA);
    assign non_pwm = !is_fast && !is_pc;
    assign top_oca = (mode == tw_pkg::TW_CTC) || (mode == tw_pkg::TW_PC_OCA) || (mode == tw_pkg::TW_FAST_OCA);
    assign top = top_oca ? oca_q : `TW_MAX;

    assign pif.sel = ctl_b_q[`TW_F_CLK_SEL];
    assign tick = pif.tick;
    assign at_top = (cnt_q == top);
    assign at_bot = (cnt_q == `TW_BOTTOM);

    // The first tick after a counter write sees no match.
    assign hit_a = tick && !blk_q && (cnt_q == oca_q);
    assign hit_b = tick && !blk_q && (cnt_q == ocb_q);

    // Turning point: the wrap in fast PWM, the peak in phase correct.
    assign turn = tick && at_top && (is_fast || (is_pc && dir_q == tw_pkg::TW_UP));

    always_comb begin
        ovf_ev = 1'b0;
        if (tick) begin
            if (is_pc) begin
                ovf_ev = at_bot && (dir_q == tw_pkg::TW_DOWN);
            end else if (mode == tw_pkg::TW_FAST_OCA) begin
                ovf_ev = at_top;
            end else begin
                ovf_ev = (cnt_q == `TW_MAX);
            end
        end
    end

    // Buffered compares move to the active copy at TOP in the PWM modes, and at once in the non-PWM modes.
    assign upd = non_pwm || turn;

    // Forcing is a strobe on the write itself, so it never reaches the flags or the counter.
    assign force_a = wr_ctl_b && REG_WDATA[`TW_F_FORCE_A] && non_pwm;
    assign force_b = wr_ctl_b && REG_WDATA[`TW_F_FORCE_B] && non_pwm;

    assign act_a = force_a ? tw_pkg::tw_act_e'(ctl_a_q[`TW_F_OUT_MODE_A])
        : chan_act(ctl_a_q[`TW_F_OUT_MODE_A], hit_a, oca_q == top, ctl_b_q[`TW_F_MODE_HI],
                   is_fast, is_pc, dir_q == tw_pkg::TW_UP, turn);
    assign act_b = force_b ? tw_pkg::tw_act_e'(ctl_a_q[`TW_F_OUT_MODE_B])
        : chan_act(ctl_a_q[`TW_F_OUT_MODE_B], hit_b, ocb_q == top, 1'b0,
                   is_fast, is_pc, dir_q == tw_pkg::TW_UP, turn);

    assign flg_clr = (wr_flg ? REG_WDATA[`TW_F_FLAGS] : 3'h0) | {VEC_ACK_B, VEC_ACK_A, VEC_ACK_OVF};

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        ctl_a_d = wr_ctl_a ? (REG_WDATA & `TW_CTRL_A_MASK) : ctl_a_q;
        ctl_b_d = wr_ctl_b ? REG_WDATA[`TW_CTRL_B_KEEP] : ctl_b_q;
        oca_buf_d = wr_oca ? REG_WDATA : oca_buf_q;
        ocb_buf_d = wr_ocb ? REG_WDATA : ocb_buf_q;
        oca_d = upd ? oca_buf_q : oca_q;
        ocb_d = upd ? ocb_buf_q : ocb_q;
        cnt_d = cnt_q;
        dir_d = is_pc ? dir_q : tw_pkg::TW_UP;
        blk_d = blk_q;
        if (wr_cnt) begin
            cnt_d = REG_WDATA;
            blk_d = 1'b1;
        end else if (tick) begin
            blk_d = 1'b0;
            if (is_pc) begin
                if (dir_q == tw_pkg::TW_UP) begin
                    if (at_top) begin
                        dir_d = tw_pkg::TW_DOWN;
                        cnt_d = cnt_q - 8'h01;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end else begin
                    if (at_bot) begin
                        dir_d = tw_pkg::TW_UP;
                        cnt_d = cnt_q + 8'h01;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
            end else begin
                cnt_d = at_top ? `TW_BOTTOM : cnt_q + 8'h01;
            end
        end
        wa_d = apply_act(wa_q, act_a);
        wb_d = apply_act(wb_q, act_b);
        flg_d = (flg_q & ~flg_clr) | {hit_b, hit_a, ovf_ev};
        rd_d = rd_q;
        if (REG_RE) begin
            if (REG_ADDR == `TW_OFS_CTRL_A) begin
                rd_d = ctl_a_q;
            end else if (REG_ADDR == `TW_OFS_CTRL_B) begin
                rd_d = {4'h0, ctl_b_q};
            end else if (REG_ADDR == `TW_OFS_COUNT) begin
                rd_d = cnt_q;
            end else if (REG_ADDR == `TW_OFS_CMP_A) begin
                rd_d = oca_buf_q;
            end else if (REG_ADDR == `TW_OFS_CMP_B) begin
                rd_d = ocb_buf_q;
            end else if (REG_ADDR == `TW_OFS_FLAGS) begin
                rd_d = {5'h00, flg_q};
            end else begin
                rd_d = `TW_RST_VAL;
            end
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctl_a_q <= `TW_RST_VAL;
            ctl_b_q <= 4'h0;
            cnt_q <= `TW_RST_VAL;
            oca_buf_q <= `TW_RST_VAL;
            oca_q <= `TW_RST_VAL;
            ocb_buf_q <= `TW_RST_VAL;
            ocb_q <= `TW_RST_VAL;
            rd_q <= `TW_RST_VAL;
            flg_q <= 3'h0;
            blk_q <= 1'b0;
            wa_q <= 1'b0;
            wb_q <= 1'b0;
            dir_q <= tw_pkg::TW_UP;
        end else begin
            ctl_a_q <= ctl_a_d;
            ctl_b_q <= ctl_b_d;
            cnt_q <= cnt_d;
            oca_buf_q <= oca_buf_d;
            oca_q <= oca_d;
            ocb_buf_q <= ocb_buf_d;
            ocb_q <= ocb_d;
            rd_q <= rd_d;
            flg_q <= flg_d;
            blk_q <= blk_d;
            wa_q <= wa_d;
            wb_q <= wb_d;
            dir_q <= dir_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign REG_RDATA = rd_q;
    assign FLAG_OVF = flg_q[0];
    assign FLAG_MATCH_A = flg_q[1];
    assign FLAG_MATCH_B = flg_q[2];
    assign WAVE_OUT_A = wa_q;
    assign WAVE_OUT_B = wb_q;
    assign WAVE_OUT_A_EN = |ctl_a_q[`TW_F_OUT_MODE_A];
    assign WAVE_OUT_B_EN = |ctl_a_q[`TW_F_OUT_MODE_B];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    chk_pin_take_b: assert property (
        wr_ctl_a && (REG_WDATA[5:4] != 2'h0) |=> WAVE_OUT_B_EN
    ) else $error("Channel B pin not taken over");

    chk_force_a_act: assert property (
        force_a && ctl_a_q[7:6] == 2'h3 && !wr_ctl_a |=> WAVE_OUT_A
    ) else $error("Forced compare A did not set the output");

    chk_force_noflag: assert property (
        force_a && !tick && !VEC_ACK_OVF && !VEC_ACK_A && !VEC_ACK_B |=> $stable(flg_q) && $stable(cnt_q)
    ) else $error("Forced compare touched flags or counter");

    chk_force_read: assert property (
        REG_RE && REG_ADDR == 8'hB1 |=> REG_RDATA[7:6] == 2'h0
    ) else $error("Force bits did not read as zero");

    chk_stop_tick: assert property (
        ctl_b_q[2:0] == 3'h0 |-> !tick ##1 (ctl_b_q[2:0] != 3'h0 || $stable(cnt_q) || $past(wr_cnt))
    ) else $error("Counter moved while stopped");

    chk_block_match: assert property (
        wr_cnt ##1 (tick && !wr_cnt) |-> !hit_a && !hit_b
    ) else $error("Match seen right after a counter write");

    chk_ovf_max: assert property (
        mode == tw_pkg::TW_NORMAL && tick && cnt_q == 8'hFF && !VEC_ACK_OVF |=> FLAG_OVF
    ) else $error("Overflow flag not set at MAX");

    chk_ctc_clear: assert property (
        mode == tw_pkg::TW_CTC && tick && cnt_q == oca_q && !wr_cnt |=> cnt_q == 8'h00
    ) else $error("Counter not cleared at compare A in clear-on-match mode");

    chk_pc_turn: assert property (
        is_pc && tick && dir_q == tw_pkg::TW_UP && at_top && !wr_cnt && top != 8'h00 |=>
            dir_q == tw_pkg::TW_DOWN && cnt_q == $past(cnt_q) - 8'h01
    ) else $error("Phase correct counter did not turn at TOP");

    chk_flag_clear: assert property (
        wr_flg && REG_WDATA[0] && !ovf_ev |=> !FLAG_OVF
    ) else $error("Writing one did not clear the overflow flag");

    chk_fast_bottom: assert property (
        is_fast && turn && ctl_a_q[5:4] == 2'h2 && !force_b |=> WAVE_OUT_B
    ) else $error("Non-inverting channel B not set at BOTTOM");

endmodule : tw_timer

// ==== tw_consts.svh ====
// Register offsets, field positions, reset values and prescaler counts of the waveform timer.
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH

`define TW_OFS_CTRL_A 8'hB0
`define TW_OFS_CTRL_B 8'hB1
`define TW_OFS_COUNT 8'hB2
`define TW_OFS_CMP_A 8'hB3
`define TW_OFS_CMP_B 8'hB4
`define TW_OFS_FLAGS 8'h37

`define TW_RST_VAL 8'h00
`define TW_MAX 8'hFF
`define TW_BOTTOM 8'h00

`define TW_F_OUT_MODE_A 7:6
`define TW_F_OUT_MODE_B 5:4
`define TW_F_MODE_LO 1:0
`define TW_CTRL_A_MASK 8'hF3
`define TW_F_FORCE_A 7
`define TW_F_FORCE_B 6
`define TW_F_MODE_HI 3
`define TW_F_CLK_SEL 2:0
`define TW_CTRL_B_KEEP 3:0
`define TW_F_FLAGS 2:0

`define TW_PRE_W 10
`define TW_DIV8_MASK 10'h007
`define TW_DIV32_MASK 10'h01F
`define TW_DIV64_MASK 10'h03F
`define TW_DIV128_MASK 10'h07F
`define TW_DIV256_MASK 10'h0FF
`define TW_DIV1024_MASK 10'h3FF

`endif

// ==== tw_pkg.sv ====
// Types shared by the waveform timer modules.
package tw_pkg;

    typedef enum logic [2:0] {
        TW_NORMAL = 3'h0,
        TW_PC_FF = 3'h1,
        TW_CTC = 3'h2,
        TW_FAST_FF = 3'h3,
        TW_RSV4 = 3'h4,
        TW_PC_OCA = 3'h5,
        TW_RSV6 = 3'h6,
        TW_FAST_OCA = 3'h7
    } tw_mode_e;

    typedef enum logic {
        TW_UP = 1'h0,
        TW_DOWN = 1'h1
    } tw_dir_e;

    typedef enum logic [1:0] {
        TW_HOLD = 2'h0,
        TW_TOGGLE = 2'h1,
        TW_CLEAR = 2'h2,
        TW_SET = 2'h3
    } tw_act_e;

endpackage : tw_pkg

// ==== tw_pscl_if.sv ====
// Link between the timer core and its clock prescaler.
`timescale 1ns/1ps
interface tw_pscl_if;
    logic [2:0] sel;
    logic tick;
    modport core (output sel, input tick);
    modport pre (input sel, output tick);
endinterface : tw_pscl_if

// ==== tw_prescaler.sv ====
// Free-running prescaler that turns the clock select into one-cycle timer ticks.
`timescale 1ns/1ps
`include "tw_consts.svh"
module tw_prescaler #(
    parameter int PW = `TW_PRE_W
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    tw_pscl_if.pre pif
);

    logic [PW-1:0] div_q;
    logic [PW-1:0] div_d;
    logic [PW-1:0] mask;

    // The divider is never cleared by a select change, so the first tick after a change may come early.
    always_comb begin
        div_d = div_q + {{(PW-1){1'b0}}, 1'b1};
        mask = '0;
        case (pif.sel)
            3'h2: mask = PW'(`TW_DIV8_MASK);
            3'h3: mask = PW'(`TW_DIV32_MASK);
            3'h4: mask = PW'(`TW_DIV64_MASK);
            3'h5: mask = PW'(`TW_DIV128_MASK);
            3'h6: mask = PW'(`TW_DIV256_MASK);
            3'h7: mask = PW'(`TW_DIV1024_MASK);
            default: mask = '0;
        endcase
    end

    assign pif.tick = (pif.sel != 3'h0) && ((div_q & mask) == mask);

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

endmodule : tw_prescaler

// ==== tb_timer2_waveform_control.sv ====
// Self-checking testbench for the waveform timer, driven through its register strobes.
`timescale 1ns/1ps
module tb_timer2_waveform_control;
    logic MCLK;
    logic ARST_N;
    logic [7:0] REG_ADDR;
    logic [7:0] REG_WDATA;
    logic REG_WE;
    logic REG_RE;
    logic [7:0] REG_RDATA;
    logic VEC_ACK_OVF;
    logic VEC_ACK_A;
    logic VEC_ACK_B;
    logic FLAG_OVF;
    logic FLAG_MATCH_A;
    logic FLAG_MATCH_B;
    logic WAVE_OUT_A;
    logic WAVE_OUT_A_EN;
    logic WAVE_OUT_B;
    logic WAVE_OUT_B_EN;
    int n_mismatch;
    int checks_done;

    tw_timer uut (.MCLK(MCLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
        .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .VEC_ACK_OVF(VEC_ACK_OVF), .VEC_ACK_A(VEC_ACK_A),
        .VEC_ACK_B(VEC_ACK_B), .FLAG_OVF(FLAG_OVF), .FLAG_MATCH_A(FLAG_MATCH_A), .FLAG_MATCH_B(FLAG_MATCH_B),
        .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_A_EN(WAVE_OUT_A_EN), .WAVE_OUT_B(WAVE_OUT_B),
        .WAVE_OUT_B_EN(WAVE_OUT_B_EN));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Every task starts and ends 1 ns after a rising edge.
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge MCLK);
            #1;
        end
    endtask : tick

    // The strobe is lowered and a further edge passes, so back-to-back calls never re-raise it in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WE = 1'b1;
        tick(1);
        REG_WE = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        REG_ADDR = a;
        REG_RE = 1'b1;
        tick(1);
        REG_RE = 1'b0;
        d = REG_RDATA;
        tick(1);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rdc

    task automatic wave_wait(input bit b, input logic v, output int n);
        n = 0;
        while ((b ? WAVE_OUT_B : WAVE_OUT_A) !== v && n < 2000) begin
            tick(1);
            n++;
        end
    endtask : wave_wait

    // High and low widths, in cycles, of one full period of a waveform output.
    task automatic meas(input bit b, output int h, output int l);
        int n;
        wave_wait(b, 1'b0, n);
        wave_wait(b, 1'b1, n);
        wave_wait(b, 1'b0, h);
        wave_wait(b, 1'b1, l);
    endtask : meas

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] c0;
        logic [7:0] c1;
        int h;
        int l;
        int h2;
        int l2;
        int bad;
        logic [1:0] cm [4];
        logic ex [4];
        int dv [8];
        cm = '{2'h3, 2'h1, 2'h1, 2'h2};
        ex = '{1'b1, 1'b0, 1'b1, 1'b0};
        dv = '{0, 1, 8, 32, 64, 128, 256, 1024};
        n_mismatch = 0;
        checks_done = 0;
        ARST_N = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WE = 1'b0;
        REG_RE = 1'b0;
        VEC_ACK_OVF = 1'b0;
        VEC_ACK_A = 1'b0;
        VEC_ACK_B = 1'b0;
        tick(4);
        ARST_N = 1'b1;
        // Reset values, reserved bits and an unmapped address.
        rdc(8'hB0, 8'h00);
        rdc(8'hB1, 8'h00);
        rdc(8'hB2, 8'h00);
        rdc(8'hB3, 8'h00);
        rdc(8'h37, 8'h00);
        wr(8'hB0, 8'hFF);
        rdc(8'hB0, 8'hF3);
        wr(8'hB1, 8'h38);
        rdc(8'hB1, 8'h08);
        wr(8'hB1, 8'h00);
        wr(8'hB0, 8'h00);
        wr(8'hB2, 8'h3C);
        rdc(8'hB2, 8'h3C);
        wr(8'hB3, 8'h5A);
        rdc(8'hB3, 8'h5A);
        wr(8'h50, 8'hFF);
        rdc(8'h50, 8'h00);
        // The counter is written only while stopped, except where blocking is tested.
        wr(8'hB2, 8'h07);
        // Pin ownership follows the output-mode fields.
        wr(8'hB0, 8'h10);
        check({WAVE_OUT_A_EN, WAVE_OUT_B_EN}, 2'b01);
        wr(8'hB0, 8'h80);
        check({WAVE_OUT_A_EN, WAVE_OUT_B_EN}, 2'b10);
        // Forced compares with the timer stopped in clear-on-match mode; the counter must keep its value.
        for (int i = 0; i < 4; i++) begin
            wr(8'hB0, {cm[i], cm[i], 4'h2});
            wr(8'hB1, 8'hC0);
            check(WAVE_OUT_A, ex[i]);
            check(WAVE_OUT_B, ex[i]);
            check({WAVE_OUT_A_EN, WAVE_OUT_B_EN}, 2'b11);
        end
        check({FLAG_MATCH_B, FLAG_MATCH_A, FLAG_OVF}, 3'b000);
        rdc(8'hB1, 8'h00);
        rdc(8'hB2, 8'h07);
        // Strobes are ignored in fast PWM; software here breaks its rule on purpose.
        wr(8'hB0, 8'hF3);
        wr(8'hB1, 8'hC0);
        check({WAVE_OUT_A, WAVE_OUT_B}, 2'b00);
        // Clear on match: compare A is TOP, toggle every four ticks.
        wr(8'hB1, 8'h00);
        wr(8'hB2, 8'h00);
        wr(8'hB3, 8'h03);
        wr(8'hB0, 8'h42);
        wr(8'h37, 8'h07);
        wr(8'hB1, 8'h01);
        meas(1'b0, h, l);
        check(h[15:0], 16'd4);
        check(l[15:0], 16'd4);
        check({FLAG_MATCH_A, FLAG_OVF}, 2'b10);
        VEC_ACK_A = 1'b1;
        tick(1);
        VEC_ACK_A = 1'b0;
        check(FLAG_MATCH_A, 1'b0);
        // A counter write blocks the match on the next tick.
        wr(8'hB1, 8'h00);
        wr(8'hB0, 8'h00);
        wr(8'hB2, 8'h00);
        wr(8'hB3, 8'h10);
        wr(8'h37, 8'h07);
        wr(8'hB1, 8'h01);
        wr(8'hB2, 8'h10);
        tick(5);
        check(FLAG_MATCH_A, 1'b0);
        bad = 0;
        while (FLAG_OVF !== 1'b1 && bad < 300) begin
            tick(1);
            bad++;
        end
        check(FLAG_OVF, 1'b1);
        tick(20);
        check(FLAG_MATCH_A, 1'b1);
        wr(8'h37, 8'h01);
        check({FLAG_MATCH_A, FLAG_OVF}, 2'b10);
        // Prescaler: two ticks in any span of twice the divisor.
        for (int s = 0; s < 8; s++) begin
            wr(8'hB1, 8'(s));
            rd(8'hB2, c0);
            tick((s == 0) ? 18 : 2 * dv[s] - 2);
            rd(8'hB2, c1);
            check(8'(c1 - c0), (s == 0) ? 8'h00 : 8'h02);
        end
        // Fast PWM on channel B, both polarities and the compare-at-TOP case.
        wr(8'hB1, 8'h00);
        wr(8'hB4, 8'h40);
        wr(8'hB0, 8'h23);
        wr(8'hB1, 8'h01);
        meas(1'b1, h, l);
        check(16'(h + l), 16'd256);
        check(h >= 63 && h <= 65, 1'b1);
        wr(8'hB0, 8'h33);
        meas(1'b1, h2, l2);
        check(h2[15:0], l[15:0]);
        wr(8'hB0, 8'h23);
        wr(8'hB4, 8'hFF);
        tick(300);
        bad = 0;
        repeat (300) begin
            tick(1);
            if (WAVE_OUT_B !== 1'b1) begin
                bad++;
            end
        end
        check(bad[15:0], 16'd0);
        // Phase correct on channel B: up to TOP, then down.
        wr(8'hB4, 8'h40);
        wr(8'hB0, 8'h21);
        meas(1'b1, h, l);
        check(16'(h + l), 16'd510);
        check(h >= 126 && h <= 130, 1'b1);
        wr(8'h37, 8'h07);
        tick(520);
        check({FLAG_MATCH_B, FLAG_OVF}, 2'b11);
        VEC_ACK_OVF = 1'b1;
        VEC_ACK_B = 1'b1;
        tick(1);
        VEC_ACK_OVF = 1'b0;
        VEC_ACK_B = 1'b0;
        check({FLAG_MATCH_B, FLAG_OVF}, 2'b00);
        // Fast PWM with compare A as TOP: channel A toggles on each match, overflow at TOP.
        wr(8'hB1, 8'h00);
        wr(8'hB0, 8'h00);
        wr(8'hB3, 8'h0F);
        wr(8'hB2, 8'h00);
        wr(8'hB0, 8'h43);
        wr(8'h37, 8'h07);
        wr(8'hB1, 8'h09);
        meas(1'b0, h, l);
        check(h[15:0], 16'd16);
        check(l[15:0], 16'd16);
        check({FLAG_MATCH_A, FLAG_OVF}, 2'b11);
        // Phase correct with compare A as TOP, then compare B moved onto TOP.
        wr(8'hB1, 8'h00);
        wr(8'hB0, 8'h00);
        wr(8'hB3, 8'h20);
        wr(8'hB4, 8'h10);
        wr(8'hB2, 8'h00);
        wr(8'hB0, 8'h21);
        wr(8'hB1, 8'h09);
        meas(1'b1, h, l);
        check(16'(h + l), 16'd64);
        check(h[15:0], 16'd32);
        wr(8'hB4, 8'h20);
        tick(150);
        bad = 0;
        repeat (130) begin
            tick(1);
            if (WAVE_OUT_B !== 1'b1) begin
                bad++;
            end
        end
        check(bad[15:0], 16'd0);
        tally_and_finish();
    end
endmodule : tb_timer2_waveform_control
